// [common/sld_btn_if.sv]
// sld_btn_if: press events from the button classifier to the menu logic
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface sld_btn_if;
  logic short_p;
  logic long_p;
  logic touch_p;
  modport src (output short_p, output long_p, output touch_p);
  modport snk (input short_p, input long_p, input touch_p);
endinterface

// [common/sld_pkg.sv]
// sld_pkg: constants and types for the status led display controller
// assumes one 250 MHz system clock shared by every user of this package
package sld_pkg;

  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned CLK_KHZ     = CLK_HZ / 1000;
  // press and debounce times in ms, idle return time in s
  localparam int unsigned LONG_MS     = 1000;
  localparam int unsigned DEB_MS      = 10;
  localparam int unsigned IDLE_S      = 180;
  localparam int unsigned LONG_CYC    = LONG_MS * CLK_KHZ;
  localparam int unsigned DEB_CYC     = DEB_MS * CLK_KHZ;
  localparam longint unsigned IDLE_CYC = longint'(IDLE_S) * CLK_HZ;
  localparam int unsigned IDLE_W      = 36;

  localparam int unsigned MENU_N      = 6;
  localparam int unsigned NUM_N       = 16;
  localparam int unsigned NODE_W      = 4;

  // two bits of colour per led
  localparam logic [1:0] COL_OFF = 2'h0;
  localparam logic [1:0] COL_GRN = 2'h1;
  localparam logic [1:0] COL_RED = 2'h2;
  localparam logic [1:0] COL_ORG = 2'h3;

  // fault codes; bit k of a code lights numbered led k+1
  localparam logic [15:0] CODE_NET_ID  = 16'h0002;
  localparam logic [15:0] CODE_SERIAL  = 16'h0009;
  localparam logic [15:0] CODE_SHORT   = 16'h000a;
  localparam logic [15:0] CODE_STATION = 16'h000f;
  localparam logic [15:0] CODE_OVERV   = 16'h0100;
  localparam logic [15:0] CODE_UNDERV  = 16'h0102;
  localparam logic [7:0]  CODE_USER_HI = 8'hc0;

  // configuration mode: all menu leds and led 1
  localparam logic [15:0] CFG_NUM_MASK = 16'h0001;

  // can bus rate select values
  localparam logic [1:0] BAUD_125 = 2'h0;
  localparam logic [1:0] BAUD_250 = 2'h1;
  localparam logic [1:0] BAUD_500 = 2'h2;

  typedef enum logic [2:0] {
    MENU_NODE  = 3'h0,
    MENU_IO    = 3'h1,
    MENU_VOLT  = 3'h2,
    MENU_MEM   = 3'h3,
    MENU_RADIO = 3'h4,
    MENU_CAN   = 3'h5
  } sld_menu_t;

  typedef enum logic [1:0] {
    LVL_1 = 2'h1,
    LVL_2 = 2'h2,
    LVL_3 = 2'h3
  } sld_lvl_t;

  typedef enum logic [1:0] {
    DISP_MENU  = 2'h0,
    DISP_CFG   = 2'h1,
    DISP_FATAL = 2'h2
  } sld_disp_t;

endpackage

// [dv/sld_checker_assertions.sv]
// sld_checker: assertions on the ports of sld_top
// assumes it is bound to sld_top and shares its clock and reset
`timescale 1ns/100ps
module sld_checker
  import sld_pkg::*;
#(
  parameter logic [NODE_W-1:0] NODE_MAX = 4'hf
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [1:0]  baud_sel,
  input wire logic        config_mode,
  input wire logic [11:0] menu_led,
  input wire logic [31:0] num_led,
  input wire logic [2:0]  menu_sel,
  input wire logic [1:0]  menu_level,
  input wire logic [3:0]  node_sel,
  input wire logic        fatal,
  input wire logic [15:0] fatal_code,
  input wire logic        io_force_off,
  input wire logic        comm_halt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_cfg;
    (config_mode && !fatal)[*3];
  endsequence
  sequence s_can;
    (menu_sel == 3'h5 && menu_level == 2'h3 && !fatal && !config_mode
      && baud_sel == BAUD_250)[*3];
  endsequence
  sequence s_sub;
    (menu_level != 2'h1) ##1 (menu_level != 2'h1);
  endsequence
  property p_fled; fatal |-> menu_led == 12'haaa; endproperty
  property p_fout; fatal |-> io_force_off && comm_halt; endproperty
  property p_flatch; fatal |=> fatal && $stable(fatal_code); endproperty
  property p_cfg; s_cfg |-> menu_led == 12'hfff && num_led == 32'h3;
  endproperty
  property p_can; s_can |-> num_led == 32'h4; endproperty
  property p_org;
    (menu_level == 2'h3 && !fatal && !config_mode)[*3]
      |-> menu_led[2*menu_sel+:2] == COL_ORG;
  endproperty
  property p_sub; s_sub |-> $stable(menu_sel); endproperty
  property p_step;
    menu_level != $past(menu_level)
      |-> menu_level == $past(menu_level) + 2'h1 || menu_level == 2'h1;
  endproperty
  property p_node; node_sel <= NODE_MAX; endproperty
  a_fled: assert property (p_fled)
    else $error("fatal menu leds wrong");
  a_fout: assert property (p_fout)
    else $error("fatal outputs not forced");
  a_flatch: assert property (p_flatch)
    else $error("fatal state not held");
  a_cfg: assert property (p_cfg)
    else $error("config display wrong");
  a_can: assert property (p_can)
    else $error("can rate display wrong");
  a_org: assert property (p_org)
    else $error("level three led not orange");
  a_sub: assert property (p_sub)
    else $error("menu changed in sub level");
  a_step: assert property (p_step)
    else $error("level skipped");
  a_node: assert property (p_node)
    else $error("node select out of range");
endmodule
bind sld_top sld_checker #(.NODE_MAX(NODE_MAX)) sld_checker_inst (
  .clk(clk), .arst_n(arst_n), .baud_sel(baud_sel),
  .config_mode(config_mode), .menu_led(menu_led), .num_led(num_led),
  .menu_sel(menu_sel), .menu_level(menu_level), .node_sel(node_sel),
  .fatal(fatal), .fatal_code(fatal_code), .io_force_off(io_force_off),
  .comm_halt(comm_halt)
);

// [dv/sld_operator.sv]
// sld_operator: operator model pressing the button
// assumes the bench clock; an untouched button reads low
`timescale 1ns/100ps
module sld_operator (
  input  wire logic clk,
  output logic      button_raw
);
  initial button_raw = 1'b0;
  task automatic press(input int n);
    @(negedge clk) button_raw = 1'b1;
    repeat (n) @(negedge clk);
    button_raw = 1'b0;
    repeat (14) @(negedge clk);
  endtask
endmodule

// [dv/tb.sv]
// tb: self-checking bench for sld_top
// assumes debounce 4, long 20, idle 200 cycles and three nodes
`timescale 1ns/100ps
module tb;
  import sld_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        button_raw;
  logic [1:0]  baud_sel = 2'h1;
  logic        config_mode = 1'b0;
  logic [6:0]  flt = 7'h0;
  logic [7:0]  ufn = 8'h5a;
  logic [31:0] page = 32'h9c63_1e27;
  logic [11:0] menu_led;
  logic [31:0] num_led;
  logic [2:0]  menu_sel;
  logic [1:0]  menu_level;
  logic [3:0]  node_sel;
  logic        fatal;
  logic [15:0] fatal_code;
  logic        io_force_off;
  logic        comm_halt;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [15:0] codes [8] = '{CODE_NET_ID, CODE_SERIAL, CODE_SHORT,
    CODE_STATION, CODE_OVERV, CODE_UNDERV, 16'hc05a, CODE_NET_ID};
  always #2 clk = ~clk;
  sld_operator sld_operator_inst (.clk(clk), .button_raw(button_raw));
  sld_top #(.DEB(4), .LONG(20), .IDLE(36'hc8), .NODE_MAX(4'h2))
  sld_top_inst (
    .clk(clk), .arst_n(arst_n), .button_raw(button_raw),
    .baud_sel(baud_sel), .config_mode(config_mode),
    .missing_net_identifier_fault(flt[0]),
    .invalid_serial_setting_fault(flt[1]), .output_short_fault(flt[2]),
    .invalid_station_index_fault(flt[3]), .overvoltage_fault(flt[4]),
    .undervoltage_fault(flt[5]), .user_fault(flt[6]),
    .user_fault_num(ufn), .page_leds(page), .menu_led(menu_led),
    .num_led(num_led), .menu_sel(menu_sel), .menu_level(menu_level),
    .node_sel(node_sel), .fatal(fatal), .fatal_code(fatal_code),
    .io_force_off(io_force_off), .comm_halt(comm_halt)
  );
  task automatic print_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic sp; sld_operator_inst.press(10); endtask
  task automatic lp; sld_operator_inst.press(32); endtask
  function automatic logic [31:0] fnum(input logic [15:0] c);
    fnum = 32'h0;
    for (int k = 0; k < 16; k++)
      if (c[k]) fnum[2*k+:2] = COL_RED;
  endfunction
  task automatic t_menu1;
    chk("lvl", 32'h1, 32'(menu_level));
    chk("mled", 32'h1, 32'(menu_led));
    chk("nled", page, num_led);
    for (int i = 1; i <= 6; i++) begin
      sp();
      chk("sel", 32'(i % 6), 32'(menu_sel));
      chk("mled", 32'h1 << (2 * (i % 6)), 32'(menu_led));
    end
    page = 32'h63c2_e1d8;
    repeat (2) @(negedge clk);
    chk("nled", page, num_led);
  endtask
  task automatic t_sub;
    lp();
    chk("lvl", 32'h2, 32'(menu_level));
    chk("mled", 32'h2, 32'(menu_led));
    sp();
    chk("sel", 32'h0, 32'(menu_sel));
    lp();
    chk("lvl", 32'h1, 32'(menu_level));
  endtask
  task automatic t_volt;
    sp();
    sp();
    lp();
    for (int i = 1; i <= 3; i++) begin
      sp();
      chk("node", 32'(i % 3), 32'(node_sel));
    end
    lp();
    chk("mled", 32'h30, 32'(menu_led));
    lp();
    chk("lvl", 32'h1, 32'(menu_level));
  endtask
  task automatic t_can;
    repeat (3) sp();
    lp();
    lp();
    chk("lvl", 32'h3, 32'(menu_level));
    for (int b = 0; b < 4; b++) begin
      baud_sel = 2'(b);
      repeat (4) @(negedge clk);
      chk("nled", b < 3 ? 32'h1 << (2 * b) : 32'h0, num_led);
    end
    baud_sel = 2'h1;
    lp();
    chk("lvl", 32'h1, 32'(menu_level));
  endtask
  task automatic t_idle;
    lp();
    repeat (260) @(negedge clk);
    chk("sel", 32'h0, 32'(menu_sel));
    chk("lvl", 32'h1, 32'(menu_level));
  endtask
  task automatic t_cfg;
    sp();
    config_mode = 1'b1;
    repeat (4) @(negedge clk);
    chk("mled", 32'hfff, 32'(menu_led));
    chk("nled", 32'h3, num_led);
    sp();
    chk("sel", 32'h1, 32'(menu_sel));
    config_mode = 1'b0;
  endtask
  task automatic t_fatal;
    for (int i = 0; i < 8; i++) begin
      arst_n = 1'b0;
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      ufn = (i == 6) ? 8'h00 : 8'h5a;
      flt = (i == 7) ? 7'h7f : 7'(1 << i);
      repeat (4) @(negedge clk);
      if (i == 6) begin
        chk("fatal", 32'h0, 32'(fatal));
        ufn = 8'h5a;
        repeat (4) @(negedge clk);
      end
      flt = 7'h0;
      sp();
      chk("code", 32'(codes[i]), 32'(fatal_code));
      chk("nled", fnum(codes[i]), num_led);
      chk("mled", 32'haaa, 32'(menu_led));
      chk("halt", 32'h7, 32'({fatal, io_force_off, comm_halt}));
      chk("page", 32'h8, 32'({menu_level, menu_sel}));
    end
  endtask
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_menu1();
    t_sub();
    t_volt();
    t_can();
    t_idle();
    t_cfg();
    t_fatal();
    print_verdict();
  end
endmodule

// [rtl/sld_btn.sv]
// sld_btn: synchronises, debounces and classifies the push button
// assumes button_raw is an asynchronous pin, high while touched
`timescale 1ns/100ps
module sld_btn
  import sld_pkg::*;
#(
  parameter int unsigned DEB  = DEB_CYC,
  parameter int unsigned LONG = LONG_CYC
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic button_raw,
  sld_btn_if.src    ev
);

  logic        sync1_r;
  logic        sync2_r;
  logic        stable_r;
  logic        long_done_r;
  logic [31:0] deb_cnt_r;
  logic [31:0] hold_cnt_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= button_raw;
      sync2_r <= sync1_r;
    end
  end

  // debounce filter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stable_r  <= 1'b0;
      deb_cnt_r <= '0;
    end else if (sync2_r == stable_r) begin
      deb_cnt_r <= '0;
    end else if (deb_cnt_r >= DEB - 1) begin
      stable_r  <= sync2_r;
      deb_cnt_r <= '0;
    end else begin
      deb_cnt_r <= deb_cnt_r + 32'h1;
    end
  end

  // [R17] long or short
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt_r  <= '0;
      long_done_r <= 1'b0;
      ev.short_p  <= 1'b0;
      ev.long_p   <= 1'b0;
      ev.touch_p  <= 1'b0;
    end else begin
      ev.short_p <= 1'b0;
      ev.long_p  <= 1'b0;
      ev.touch_p <= 1'b0;
      if (stable_r) begin
        if (hold_cnt_r == '0) begin
          ev.touch_p <= 1'b1;
        end
        if (!long_done_r && hold_cnt_r >= LONG - 1) begin
          ev.long_p   <= 1'b1;
          long_done_r <= 1'b1;
        end
        if (hold_cnt_r != 32'hffffffff) begin
          hold_cnt_r <= hold_cnt_r + 32'h1;
        end
      end else begin
        if (hold_cnt_r != '0 && !long_done_r) begin
          ev.short_p <= 1'b1;
        end
        hold_cnt_r  <= '0;
        long_done_r <= 1'b0;
      end
    end
  end

endmodule

// [rtl/sld_top.sv]
// sld_top: front panel led display controller, menus and fault display
// assumes fault, mode and page inputs come from logic on clk
//
// Function
// [R1] can level three lights one green led for 125, 250 or 500 kbit
// [R2] a detected internal or external fault may enter fatal error state
// [R3] fatal state forces outputs off, halts comms, shows fault code
// [R4] fatal code shows all six menu leds red plus coded leds red
// [R5] invalid serial number setting reports 0x0009 on leds 1 and 4
// [R6] invalid node number setting reports 0x000F on leds 1 to 4
// [R7] undervoltage 0x0102 on leds 9 and 2, overvoltage 0x0100 on led 9
// [R8] net id 0x0002, short 0x000A, user 0xC0xx on leds 15, 16, 1-8
// [R9] configuration mode lights six menu leds and led 1 orange
// [R10] first level shows menu led green, short press picks next menu
// [R11] one second hold enters second level, menu led turns red
// [R12] long hold steps deeper or wraps; volt and can menus have three
// [R13] short press in node data sub-levels selects the next node
// [R14] only volt and can menus have level three, shown orange
// [R15] start in node menu level one, return there after idle minutes
// [R16] short presses in sub-levels never change the first level menu
// [R17] debounced hold of one second is long, earlier release is short
// [R18] fatal and config displays win and buttons are then ignored
`timescale 1ns/100ps
module sld_top
  import sld_pkg::*;
#(
  parameter int unsigned      DEB      = DEB_CYC,
  parameter int unsigned      LONG     = LONG_CYC,
  parameter logic [IDLE_W-1:0] IDLE    = IDLE_W'(IDLE_CYC),
  parameter logic [NODE_W-1:0] NODE_MAX = 4'hf
) (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 button_raw,
  input  wire logic [1:0]           baud_sel,
  input  wire logic                 config_mode,
  input  wire logic                 missing_net_identifier_fault,
  input  wire logic                 invalid_serial_setting_fault,
  input  wire logic                 output_short_fault,
  input  wire logic                 invalid_station_index_fault,
  input  wire logic                 overvoltage_fault,
  input  wire logic                 undervoltage_fault,
  input  wire logic                 user_fault,
  input  wire logic [7:0]           user_fault_num,
  input  wire logic [2*NUM_N-1:0]   page_leds,
  output logic [2*MENU_N-1:0]       menu_led,
  output logic [2*NUM_N-1:0]        num_led,
  output logic [2:0]                menu_sel,
  output logic [1:0]                menu_level,
  output logic [NODE_W-1:0]         node_sel,
  output logic                      fatal,
  output logic [15:0]               fatal_code,
  output logic                      io_force_off,
  output logic                      comm_halt
);

  sld_btn_if btn ();

  sld_btn #(
    .DEB  (DEB),
    .LONG (LONG)
  ) u_btn (
    .clk        (clk),
    .arst_n     (arst_n),
    .button_raw (button_raw),
    .ev         (btn)
  );

  sld_menu_t         menu_r;
  sld_lvl_t          lvl_r;
  logic [NODE_W-1:0] node_r;
  logic              fatal_r;
  logic [15:0]       code_r;
  logic [IDLE_W-1:0] idle_r;
  sld_disp_t         disp;
  logic              fault_any;
  logic [15:0]       fault_code;
  logic              btn_ok;
  logic              idle_hit;
  logic [2*MENU_N-1:0] menu_led_nxt;
  logic [2*NUM_N-1:0]  num_led_nxt;

  // paint every set bit of a mask in one colour
  function automatic logic [2*NUM_N-1:0] paint(
    input logic [NUM_N-1:0] mask,
    input logic [1:0]       col
  );
    logic [2*NUM_N-1:0] res;
    res = '0;
    for (int i = 0; i < NUM_N; i++) begin
      if (mask[i]) begin
        res[2*i +: 2] = col;
      end
    end
    return res;
  endfunction

  // deepest level of a menu
  function automatic sld_lvl_t top_lvl(input sld_menu_t m);
    if (m == MENU_VOLT || m == MENU_CAN) begin
      return LVL_3;
    end
    return LVL_2;
  endfunction

  // sub-levels that page through other nodes
  function automatic logic node_page(
    input sld_menu_t m,
    input sld_lvl_t  l
  );
    return (m == MENU_VOLT && l != LVL_1) ||
           (m == MENU_MEM && l == LVL_2);
  endfunction

  // fault priority and code selection
  always_comb begin
    fault_any  = 1'b1;
    fault_code = '0;
    // [R8] net id code
    if (missing_net_identifier_fault) begin
      fault_code = CODE_NET_ID;
    // [R5] serial code
    end else if (invalid_serial_setting_fault) begin
      fault_code = CODE_SERIAL;
    // [R8] short code
    end else if (output_short_fault) begin
      fault_code = CODE_SHORT;
    // [R6] station code
    end else if (invalid_station_index_fault) begin
      fault_code = CODE_STATION;
    // [R7] overvoltage code
    end else if (overvoltage_fault) begin
      fault_code = CODE_OVERV;
    // [R7] undervoltage code
    end else if (undervoltage_fault) begin
      fault_code = CODE_UNDERV;
    // [R8] user fault code
    end else if (user_fault && user_fault_num != 8'h00) begin
      fault_code = {CODE_USER_HI, user_fault_num};
    end else begin
      fault_any = 1'b0;
    end
  end

  // [R2] latch fatal state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fatal_r <= 1'b0;
      code_r  <= '0;
    end else if (!fatal_r && fault_any) begin
      fatal_r <= 1'b1;
      code_r  <= fault_code;
    end
  end

  // [R18] display precedence
  always_comb begin
    if (fatal_r) begin
      disp = DISP_FATAL;
    end else if (config_mode) begin
      disp = DISP_CFG;
    end else begin
      disp = DISP_MENU;
    end
  end

  assign btn_ok   = (disp == DISP_MENU);
  assign idle_hit = (idle_r >= IDLE - 1);

  // [R15] idle return timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_r <= '0;
    end else if (btn.touch_p || idle_hit) begin
      idle_r <= '0;
    end else begin
      idle_r <= idle_r + IDLE_W'(1);
    end
  end

  // menu navigation
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // [R15] start menu
      menu_r <= MENU_NODE;
      lvl_r  <= LVL_1;
      node_r <= '0;
    end else if (idle_hit) begin
      // [R15] idle return
      menu_r <= MENU_NODE;
      lvl_r  <= LVL_1;
      node_r <= '0;
    end else if (btn_ok && btn.long_p) begin
      // [R11] enter second level
      // [R12] deeper or wrap
      // [R14] third level limit
      node_r <= '0;
      if (lvl_r == top_lvl(menu_r)) begin
        lvl_r <= LVL_1;
      end else if (lvl_r == LVL_1) begin
        lvl_r <= LVL_2;
      end else begin
        lvl_r <= LVL_3;
      end
    end else if (btn_ok && btn.short_p) begin
      if (lvl_r == LVL_1) begin
        // [R10] next first level menu
        if (menu_r == MENU_CAN) begin
          menu_r <= MENU_NODE;
        end else begin
          menu_r <= sld_menu_t'(menu_r + 3'h1);
        end
      end else if (node_page(menu_r, lvl_r)) begin
        // [R16] sub-level press only
        // [R13] next node
        if (node_r == NODE_MAX) begin
          node_r <= '0;
        end else begin
          node_r <= node_r + NODE_W'(1);
        end
      end
    end
  end

  // led image for the current display
  always_comb begin
    menu_led_nxt = '0;
    num_led_nxt  = '0;
    case (disp)
      DISP_FATAL: begin
        // [R4] all menu leds red plus code
        // [R3] code replaces menu
        for (int i = 0; i < MENU_N; i++) begin
          menu_led_nxt[2*i +: 2] = COL_RED;
        end
        num_led_nxt = paint(code_r, COL_RED);
      end
      DISP_CFG: begin
        // [R9] configuration pattern
        for (int i = 0; i < MENU_N; i++) begin
          menu_led_nxt[2*i +: 2] = COL_ORG;
        end
        num_led_nxt = paint(CFG_NUM_MASK, COL_ORG);
      end
      DISP_MENU: begin
        // [R10] level one green
        // [R11] level two red
        // [R14] level three orange
        case (lvl_r)
          LVL_1:   menu_led_nxt[2*menu_r +: 2] = COL_GRN;
          LVL_2:   menu_led_nxt[2*menu_r +: 2] = COL_RED;
          LVL_3:   menu_led_nxt[2*menu_r +: 2] = COL_ORG;
          default: menu_led_nxt = '0;
        endcase
        if (menu_r == MENU_CAN && lvl_r == LVL_3) begin
          // [R1] bus rate led
          case (baud_sel)
            BAUD_125: num_led_nxt = paint(16'h0001, COL_GRN);
            BAUD_250: num_led_nxt = paint(16'h0002, COL_GRN);
            BAUD_500: num_led_nxt = paint(16'h0004, COL_GRN);
            default:  num_led_nxt = '0;
          endcase
        end else begin
          num_led_nxt = page_leds;
        end
      end
      default: begin
        menu_led_nxt = '0;
        num_led_nxt  = '0;
      end
    endcase
  end

  // registered outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      menu_led   <= '0;
      num_led    <= '0;
      menu_sel   <= MENU_NODE;
      menu_level <= LVL_1;
      node_sel   <= '0;
    end else begin
      menu_led   <= menu_led_nxt;
      num_led    <= num_led_nxt;
      menu_sel   <= menu_r;
      menu_level <= lvl_r;
      node_sel   <= node_r;
    end
  end

  // [R3] force off and halt
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fatal        <= 1'b0;
      fatal_code   <= '0;
      io_force_off <= 1'b0;
      comm_halt    <= 1'b0;
    end else begin
      fatal        <= fatal_r;
      fatal_code   <= code_r;
      io_force_off <= fatal_r;
      comm_halt    <= fatal_r;
    end
  end

endmodule
